// File: pkg/uart_pair_defs.vh
// register map, field positions and timing constants for the dual serial channel block
`ifndef UART_PAIR_DEFS_VH
`define UART_PAIR_DEFS_VH
`define OFS_POWER_CTL 16'h0087
`define OFS_BAUD_SRC 16'h00D8
`define OFS_PIN_ROUTE 16'hFFF1
`define OFS_CH0_CTL 16'h0098
`define OFS_CH0_BUF 16'h0099
`define OFS_CH1_CTL 16'h009A
`define OFS_CH1_BUF 16'h009B
`define OFS_CH0_REL_LO 16'h00AA
`define OFS_CH0_REL_HI 16'h00BA
`define OFS_CH1_REL_LO 16'h009D
`define OFS_CH1_REL_HI 16'h00BB
`define OFS_INT_STAT 16'h00E0
`define OFS_INT_MASK 16'h00E1
`define OFS_FRAME_CFG 16'h00E2
`define REG_RESET 8'h00
`define RD_UNMAPPED 8'h00
`define PC_DOUBLE 7
`define PC_STOP 1
`define PC_IDLE 0
`define BS_SEL 7
`define PR_PWRDN 7
`define PR_LOOP 1
`define PR_SEL 0
`define CTL_MODE_HI 7
`define CTL_MODE_LO 6
`define CTL_PAR 5
`define CTL_REN 4
`define CTL_TB8 3
`define CTL_RB8 2
`define CTL_TI 1
`define CTL_RI 0
`define FC_ODD 0
`define FC_TWO 1
`define FC_FLOW 2
`define FC_STRIDE 4
`define IS_RX0 0
`define IS_TX0 1
`define IS_RX1 2
`define IS_TX1 3
`define IS_PE0 4
`define IS_PE1 5
`define IS_LAST 5
`define IS_W 6
`define MODE_0 2'h0
`define MODE_1 2'h1
`define MODE_2 2'h2
`define VEC_CH0 16'h0023
`define VEC_CH1 16'h0083
`define VEC_NONE 16'h0000
`define XON_CODE 8'h11
`define XOFF_CODE 8'h13
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`define BITS_BASE 4'hA
`define DATA_BITS 4'h8
`define LAST_BIT 4'h1
`define PRESCALE_LAST 4'hA
`define REL_WRAP 10'h3FF
`define TIMER_REL_HI 2'h3
`define FIX_DIV_FAST 2'h1
`define FIX_DIV_SLOW 2'h3
`define RATE_MIN_BPS 300
`define RATE_MAX_BPS 115200
`endif

// File: hw/baud_tick_gen.v
// reload counter producing the 16x oversampling tick of one rate source
`timescale 1ns/1ps
`default_nettype none
`include "uart_pair_defs.vh"
module baud_tick_gen (
  input wire ref_clk, // system clock
  input wire rst_n, // async reset, active low
  input wire [9:0] reload, // counter restarts here after wrapping
  input wire double_rate, // skips the divide by two
  output reg tick_q // one-cycle 16x tick
);
  reg [3:0] pre_q;
  reg half_q;
  reg [9:0] cnt_q;
  wire step = (pre_q == `PRESCALE_LAST) && (half_q || double_rate);

  // prescale keeps the slowest reload near the lowest supported rate at 100 MHz
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 4'h0;
      half_q <= 1'b0;
      cnt_q <= 10'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (pre_q == `PRESCALE_LAST) begin
        pre_q <= 4'h0;
        half_q <= ~half_q;
      end else begin
        pre_q <= pre_q + 4'h1;
      end
      if (step) begin
        if (cnt_q == `REL_WRAP) begin
          cnt_q <= reload;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end
endmodule // baud_tick_gen
`default_nettype wire

// File: hw/uart_channel.v
// one serial channel: frame transmitter and oversampling receiver
`timescale 1ns/1ps
`default_nettype none
`include "uart_pair_defs.vh"
module uart_channel (
  input wire ref_clk, // system clock
  input wire rst_n, // async reset, active low
  input wire tick, // 16x bit tick
  input wire enable, // channel usable in its mode
  input wire ninth_en, // frame carries a ninth bit
  input wire par_en, // ninth bit is parity
  input wire par_odd, // odd parity when set
  input wire two_stop, // two stop bits
  input wire flow_en, // xon/xoff pause of transmitter
  input wire rx_en, // reception enable
  input wire tx_ninth, // software ninth bit
  input wire tx_start, // pulse: queue tx_data
  input wire [7:0] tx_data, // byte to send
  input wire rxd, // serial input, idle high
  output reg txd_q, // serial output
  output reg tx_done_q, // pulse at end of frame
  output wire tx_busy, // byte queued or shifting
  output reg [7:0] rx_data_q, // last received byte
  output reg rx_ninth_q, // ninth bit, or stop bit without one
  output reg rx_done_q, // pulse on frame received
  output reg rx_perr_q // pulse with rx_done on parity mismatch
);
  localparam T_IDLE = 2'b01;
  localparam T_SEND = 2'b10;
  localparam R_IDLE = 3'b001;
  localparam R_START = 3'b010;
  localparam R_BITS = 3'b100;
  reg [1:0] tst_q;
  reg [11:0] tsh_q;
  reg [3:0] tbits_q;
  reg [3:0] tovs_q;
  reg pend_q;
  reg [7:0] hold_q;
  reg paused_q;
  reg [2:0] rxs_q;
  reg rx_prev_q;
  reg [3:0] rovs_q;
  reg [3:0] ridx_q;
  reg [7:0] rsh_q;
  reg rnine_q;
  wire par_bit = ^hold_q ^ par_odd;
  wire nine = par_en ? par_bit : tx_ninth;
  wire [3:0] rlast = `DATA_BITS + {3'h0, ninth_en};
  assign tx_busy = pend_q || (tst_q == T_SEND);

  // transmitter; a write while busy is dropped, software waits for the done flag
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tst_q <= T_IDLE;
      tsh_q <= 12'hFFF;
      tbits_q <= 4'h0;
      tovs_q <= 4'h0;
      pend_q <= 1'b0;
      hold_q <= 8'h00;
      txd_q <= 1'b1;
      tx_done_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      if (tx_start && enable && !tx_busy) begin
        pend_q <= 1'b1;
        hold_q <= tx_data;
      end
      case (tst_q)
        T_IDLE: begin
          txd_q <= 1'b1;
          if (pend_q && !paused_q && tick) begin
            // start bit in bit 0, data lsb first after it
            tsh_q <= ninth_en ? {2'b11, nine, hold_q, 1'b0} : {3'b111, hold_q, 1'b0};
            tbits_q <= `BITS_BASE + {3'h0, ninth_en} + {3'h0, two_stop};
            tovs_q <= 4'h0;
            pend_q <= 1'b0;
            tst_q <= T_SEND;
          end
        end
        T_SEND: begin
          txd_q <= tsh_q[0];
          if (tick) begin
            if (tovs_q == `OVS_LAST) begin
              tovs_q <= 4'h0;
              tsh_q <= {1'b1, tsh_q[11:1]};
              tbits_q <= tbits_q - 4'h1;
              if (tbits_q == `LAST_BIT) begin
                tst_q <= T_IDLE;
                tx_done_q <= 1'b1;
              end
            end else begin
              tovs_q <= tovs_q + 4'h1;
            end
          end
        end
        default: tst_q <= T_IDLE;
      endcase
    end
  end

  // receiver: falling edge starts, start bit rechecked mid-bit, later bits sampled at centre
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxs_q <= R_IDLE;
      rx_prev_q <= 1'b1;
      rovs_q <= 4'h0;
      ridx_q <= 4'h0;
      rsh_q <= 8'h00;
      rnine_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_ninth_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_perr_q <= 1'b0;
      paused_q <= 1'b0;
    end else begin
      rx_prev_q <= rxd;
      rx_done_q <= 1'b0;
      rx_perr_q <= 1'b0;
      if (!flow_en) begin
        paused_q <= 1'b0;
      end
      case (rxs_q)
        R_IDLE: begin
          if (enable && rx_en && rx_prev_q && !rxd) begin
            rxs_q <= R_START;
            rovs_q <= 4'h0;
          end
        end
        R_START: begin
          if (tick) begin
            if (rovs_q == `OVS_MID) begin
              rovs_q <= 4'h0;
              ridx_q <= 4'h0;
              rxs_q <= rxd ? R_IDLE : R_BITS; // glitch rejected
            end else begin
              rovs_q <= rovs_q + 4'h1;
            end
          end
        end
        R_BITS: begin
          if (tick) begin
            if (rovs_q == `OVS_LAST) begin
              rovs_q <= 4'h0;
              ridx_q <= ridx_q + 4'h1;
              if (ridx_q < `DATA_BITS) begin
                rsh_q[ridx_q[2:0]] <= rxd;
              end else if (ridx_q != rlast) begin
                rnine_q <= rxd;
              end else begin
                rxs_q <= R_IDLE;
                rx_done_q <= 1'b1;
                rx_data_q <= rsh_q;
                rx_ninth_q <= ninth_en ? rnine_q : rxd;
                rx_perr_q <= par_en && ninth_en && ((^rsh_q ^ par_odd) != rnine_q);
                if (flow_en && rsh_q == `XOFF_CODE) begin
                  paused_q <= 1'b1;
                end else if (flow_en && rsh_q == `XON_CODE) begin
                  paused_q <= 1'b0;
                end
              end
            end else begin
              rovs_q <= rovs_q + 4'h1;
            end
          end
        end
        default: rxs_q <= R_IDLE;
      endcase
    end
  end
endmodule // uart_channel
`default_nettype wire

// File: hw/dual_uart_baud_select.v
// two serial channels sharing one pin pair, rate source selection, registers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "uart_pair_defs.vh"
module dual_uart_baud_select (
  input wire ref_clk, // 100 MHz system clock
  input wire rst_n, // async reset, active low
  input wire [15:0] addr, // register address
  input wire wr_en, // write strobe
  input wire rd_en, // read strobe
  input wire [7:0] wr_data, // write data
  output reg [7:0] rd_data_q, // read data, cycle after rd_en
  input wire rxd, // receive pin
  output wire txd, // transmit pin
  input wire [7:0] timer1_upper_byte, // running upper byte of timer 1
  input wire cpu_wake, // pulse: cpu left stop or idle
  output wire irq, // level, any unmasked status bit
  output reg [15:0] irq_vector_q, // vector of highest pending channel
  output wire stop_req, // stop mode request
  output wire idle_req, // idle mode request
  output wire power_down // power down request
);
  reg [7:0] power_control_q;
  reg [7:0] baud_source_control_q;
  reg [7:0] route_q;
  reg [7:0] ctl0_q;
  reg [7:0] ctl1_q;
  reg [7:0] rel_lo0_q;
  reg [7:0] rel_hi0_q;
  reg [7:0] rel_lo1_q;
  reg [7:0] rel_hi1_q;
  reg [7:0] frame_q;
  reg [`IS_LAST:0] stat_q;
  reg [`IS_LAST:0] mask_q;
  reg [`IS_LAST:0] stat_d;
  reg [7:0] rd_d;
  reg [1:0] fix_q;
  reg fix_tick_q;
  reg [1:0] start_q;
  reg [7:0] txbyte_q;

  wire double_rate = power_control_q[`PC_DOUBLE];
  wire use_gen = baud_source_control_q[`BS_SEL];
  wire loop_en = route_q[`PR_LOOP];
  wire sel1 = route_q[`PR_SEL];
  wire [1:0] mode0 = ctl0_q[`CTL_MODE_HI:`CTL_MODE_LO];
  wire [1:0] ch_tick;
  wire [1:0] ch_en;
  wire [1:0] ch_ninth;
  wire [1:0] ch_par;
  wire [1:0] ch_ren;
  wire [1:0] ch_tb8;
  wire [1:0] ch_rx;
  wire [1:0] ch_tx;
  wire [1:0] tx_done;
  wire [1:0] rx_done;
  wire [1:0] rx_perr;
  wire [1:0] rx_ninth;
  wire [15:0] rx_data;
  wire [1:0] busy;
  wire gen0_tick;
  wire gen1_tick;
  wire t1_tick;
  wire wr_stat = wr_en && (addr == `OFS_INT_STAT);
  wire [`IS_LAST:0] pend = stat_q & mask_q;
  wire pend0 = pend[`IS_RX0] || pend[`IS_TX0] || pend[`IS_PE0];
  wire pend1 = pend[`IS_RX1] || pend[`IS_TX1] || pend[`IS_PE1];

  // dedicated generators, reload assembled from the two reload registers
  baud_tick_gen u_gen0 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reload({rel_hi0_q[1:0], rel_lo0_q}),
    .double_rate(double_rate),
    .tick_q(gen0_tick)
  );
  baud_tick_gen u_gen1 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reload({rel_hi1_q[1:0], rel_lo1_q}),
    .double_rate(double_rate),
    .tick_q(gen1_tick)
  );
  // timer 1 path counts up from its upper byte, so the divisor is 256 minus that byte
  baud_tick_gen u_gen_t1 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reload({`TIMER_REL_HI, timer1_upper_byte}),
    .double_rate(double_rate),
    .tick_q(t1_tick)
  );

  // mode 2 fixed rate: tick every 2 or 4 clocks gives 32 or 64 clocks per bit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fix_q <= 2'h0;
      fix_tick_q <= 1'b0;
    end else begin
      if (fix_q == (double_rate ? `FIX_DIV_FAST : `FIX_DIV_SLOW)) begin
        fix_q <= 2'h0;
        fix_tick_q <= 1'b1;
      end else begin
        fix_q <= fix_q + 2'h1;
        fix_tick_q <= 1'b0;
      end
    end
  end

  // per-channel frame selection; channel 0 mode 0 is not available and stays off
  assign ch_tick[0] = (mode0 == `MODE_2) ? fix_tick_q : (use_gen ? gen0_tick : t1_tick);
  assign ch_tick[1] = gen1_tick;
  assign ch_en[0] = (mode0 != `MODE_0);
  assign ch_en[1] = 1'b1;
  assign ch_ninth[0] = (mode0 != `MODE_1);
  assign ch_ninth[1] = 1'b1;
  assign ch_par[0] = ctl0_q[`CTL_PAR];
  assign ch_par[1] = ctl1_q[`CTL_PAR];
  assign ch_ren[0] = ctl0_q[`CTL_REN];
  assign ch_ren[1] = ctl1_q[`CTL_REN];
  assign ch_tb8[0] = ctl0_q[`CTL_TB8];
  assign ch_tb8[1] = ctl1_q[`CTL_TB8];

  // pin routing; in loopback the unselected channel listens to the selected transmitter
  assign txd = sel1 ? ch_tx[1] : ch_tx[0];
  assign ch_rx[0] = loop_en ? (sel1 ? ch_tx[1] : 1'b1) : (sel1 ? 1'b1 : rxd);
  assign ch_rx[1] = loop_en ? (sel1 ? 1'b1 : ch_tx[0]) : (sel1 ? rxd : 1'b1);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      uart_channel u_ch (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(ch_tick[g]),
        .enable(ch_en[g]),
        .ninth_en(ch_ninth[g]),
        .par_en(ch_par[g]),
        .par_odd(frame_q[g * `FC_STRIDE + `FC_ODD]),
        .two_stop(frame_q[g * `FC_STRIDE + `FC_TWO]),
        .flow_en(frame_q[g * `FC_STRIDE + `FC_FLOW]),
        .rx_en(ch_ren[g]),
        .tx_ninth(ch_tb8[g]),
        .tx_start(start_q[g]),
        .tx_data(txbyte_q),
        .rxd(ch_rx[g]),
        .txd_q(ch_tx[g]),
        .tx_done_q(tx_done[g]),
        .tx_busy(busy[g]),
        .rx_data_q(rx_data[g * 8 +: 8]),
        .rx_ninth_q(rx_ninth[g]),
        .rx_done_q(rx_done[g]),
        .rx_perr_q(rx_perr[g])
      );
    end
  endgenerate

  // sticky status: a hardware set in the same cycle as a write-one clear wins
  always @* begin
    stat_d = stat_q & ~(wr_stat ? wr_data[`IS_LAST:0] : {`IS_W{1'b0}});
    stat_d[`IS_RX0] = stat_d[`IS_RX0] | rx_done[0];
    stat_d[`IS_TX0] = stat_d[`IS_TX0] | tx_done[0];
    stat_d[`IS_RX1] = stat_d[`IS_RX1] | rx_done[1];
    stat_d[`IS_TX1] = stat_d[`IS_TX1] | tx_done[1];
    stat_d[`IS_PE0] = stat_d[`IS_PE0] | rx_perr[0];
    stat_d[`IS_PE1] = stat_d[`IS_PE1] | rx_perr[1];
  end

  assign irq = |pend;
  assign stop_req = power_control_q[`PC_STOP];
  assign idle_req = power_control_q[`PC_IDLE];
  assign power_down = route_q[`PR_PWRDN];

  // register writes; ctl bits for ri/ti and rb8 are not writable here
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control_q <= `REG_RESET;
      baud_source_control_q <= `REG_RESET;
      route_q <= `REG_RESET;
      ctl0_q <= `REG_RESET;
      ctl1_q <= `REG_RESET;
      rel_lo0_q <= `REG_RESET;
      rel_hi0_q <= `REG_RESET;
      rel_lo1_q <= `REG_RESET;
      rel_hi1_q <= `REG_RESET;
      frame_q <= `REG_RESET;
      stat_q <= {`IS_W{1'b0}};
      mask_q <= {`IS_W{1'b0}};
      start_q <= 2'b00;
      txbyte_q <= `REG_RESET;
      irq_vector_q <= `VEC_NONE;
    end else begin
      stat_q <= stat_d;
      start_q <= 2'b00;
      // channel 0 outranks channel 1 when both are pending
      irq_vector_q <= pend0 ? `VEC_CH0 : (pend1 ? `VEC_CH1 : `VEC_NONE);
      // a wake from the cpu ends stop or idle; a write in the same cycle takes over
      if (cpu_wake) begin
        power_control_q[`PC_STOP] <= 1'b0;
        power_control_q[`PC_IDLE] <= 1'b0;
      end
      if (rx_done[0]) begin
        ctl0_q[`CTL_RB8] <= rx_ninth[0];
      end
      if (rx_done[1]) begin
        ctl1_q[`CTL_RB8] <= rx_ninth[1];
      end
      if (wr_en) begin
        case (addr)
          `OFS_POWER_CTL: power_control_q <= wr_data;
          `OFS_BAUD_SRC: baud_source_control_q <= wr_data;
          `OFS_PIN_ROUTE: route_q <= wr_data;
          `OFS_CH0_CTL: ctl0_q[`CTL_MODE_HI:`CTL_TB8] <= wr_data[`CTL_MODE_HI:`CTL_TB8];
          `OFS_CH1_CTL: ctl1_q[`CTL_MODE_HI:`CTL_TB8] <= wr_data[`CTL_MODE_HI:`CTL_TB8];
          `OFS_CH0_REL_LO: rel_lo0_q <= wr_data;
          `OFS_CH0_REL_HI: rel_hi0_q <= wr_data;
          `OFS_CH1_REL_LO: rel_lo1_q <= wr_data;
          `OFS_CH1_REL_HI: rel_hi1_q <= wr_data;
          `OFS_FRAME_CFG: frame_q <= wr_data;
          `OFS_INT_MASK: mask_q <= wr_data[`IS_LAST:0];
          `OFS_CH0_BUF: begin
            start_q[0] <= 1'b1;
            txbyte_q <= wr_data;
          end
          `OFS_CH1_BUF: begin
            start_q[1] <= 1'b1;
            txbyte_q <= wr_data;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always @* begin
    rd_d = `RD_UNMAPPED;
    case (addr)
      `OFS_POWER_CTL: rd_d = power_control_q;
      `OFS_BAUD_SRC: rd_d = baud_source_control_q;
      `OFS_PIN_ROUTE: rd_d = route_q;
      `OFS_CH0_CTL: rd_d = {ctl0_q[`CTL_MODE_HI:`CTL_RB8], stat_q[`IS_TX0], stat_q[`IS_RX0]};
      `OFS_CH1_CTL: rd_d = {ctl1_q[`CTL_MODE_HI:`CTL_RB8], stat_q[`IS_TX1], stat_q[`IS_RX1]};
      `OFS_CH0_BUF: rd_d = rx_data[7:0];
      `OFS_CH1_BUF: rd_d = rx_data[15:8];
      `OFS_CH0_REL_LO: rd_d = rel_lo0_q;
      `OFS_CH0_REL_HI: rd_d = rel_hi0_q;
      `OFS_CH1_REL_LO: rd_d = rel_lo1_q;
      `OFS_CH1_REL_HI: rd_d = rel_hi1_q;
      `OFS_FRAME_CFG: rd_d = frame_q;
      `OFS_INT_STAT: rd_d = {2'b00, stat_q};
      `OFS_INT_MASK: rd_d = {2'b00, mask_q};
      default: rd_d = `RD_UNMAPPED;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= `REG_RESET;
    end else begin
      rd_data_q <= rd_en ? rd_d : `REG_RESET;
    end
  end
endmodule // dual_uart_baud_select
`default_nettype wire

// File: verification/dual_uart_chk.sv
// port checker for the dual serial channel block
`timescale 1ns/1ps
`default_nettype none
`include "uart_pair_defs.vh"
module dual_uart_chk (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [15:0] addr, // register address
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [7:0] wr_data, // write data
  input wire logic [7:0] rd_data_q, // read data
  input wire logic txd, // transmit pin
  input wire logic cpu_wake, // wake pulse
  input wire logic irq, // interrupt level
  input wire logic [15:0] irq_vector_q, // pending vector
  input wire logic stop_req, // stop request
  input wire logic idle_req, // idle request
  input wire logic power_down // power down request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire pc_wr = wr_en && addr == `OFS_POWER_CTL;
  wire rt_wr = wr_en && addr == `OFS_PIN_ROUTE;
  // even the fastest fixed rate keeps a bit low for 32 clocks
  sequence low_run_s;
    !txd [*8];
  endsequence
  rd_quiet_a: assert property (!rd_en |=> rd_data_q == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a: assert property (rd_en && addr == 16'h0001 |=> rd_data_q == 8'h00)
    else $error("unmapped read not zero");
  vec_pend_a: assert property (irq |=> irq_vector_q == `VEC_CH0 || irq_vector_q == `VEC_CH1)
    else $error("vector missing while pending");
  vec_none_a: assert property (!irq |=> irq_vector_q == `VEC_NONE)
    else $error("vector without pending");
  pc_write_a: assert property (pc_wr |=> {stop_req, idle_req} == $past(wr_data[1:0]))
    else $error("stop or idle not written");
  pc_hold_a: assert property (!pc_wr |=> !$rose(stop_req) && !$rose(idle_req))
    else $error("stop or idle rose alone");
  wake_clear_a: assert property (cpu_wake && !wr_en |=> !stop_req && !idle_req)
    else $error("wake left a request");
  mask_off_a: assert property (wr_en && addr == `OFS_INT_MASK && wr_data == 8'h00 |=> !irq)
    else $error("masked interrupt raised");
  pdown_write_a: assert property (rt_wr |=> power_down == $past(wr_data[7]))
    else $error("power down not written");
  start_len_a: assert property ($fell(txd) |-> low_run_s)
    else $error("start bit too short");
endmodule // dual_uart_chk
`default_nettype wire

// File: verification/host_uart_model.sv
// behavioural host on the far end of the serial pins
`timescale 1ns/1ps
`default_nettype none
module host_uart_model (
  input wire logic ref_clk, // system clock
  input wire logic txd, // device transmit pin
  output logic rxd // device receive pin, idle high
);
  initial rxd = 1'b1;
  // one frame, start, eight bits lsb first, stop, at the given rate
  task automatic send(input logic [7:0] d, input int cpb);
    int i;
    for (i = 0; i < 10; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (cpb) @(posedge ref_clk);
    end
  endtask
  // sample at bit centres; ok reports start low and stop high
  task automatic recv(input int cpb, input int n, output logic [8:0] d, output logic ok);
    int i;
    int w;
    d = 9'h000;
    w = 0;
    // a rate counter still on its first wrap after reset may take over 11000 clocks to tick
    while (txd !== 1'b0 && w < 12000) begin
      @(posedge ref_clk);
      w++;
    end
    repeat (cpb / 2) @(posedge ref_clk);
    ok = (txd === 1'b0);
    for (i = 0; i < n; i++) begin
      repeat (cpb) @(posedge ref_clk);
      d[i] = txd;
    end
    repeat (cpb) @(posedge ref_clk);
    ok = ok && (txd === 1'b1);
  endtask
endmodule // host_uart_model
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the dual serial channel block
`timescale 1ns/1ps
`default_nettype none
`include "uart_pair_defs.vh"
module tb_top;
  localparam int CPB = 176; // reload 0x3FF, doubled: 11 clocks a tick, 16 ticks a bit
  logic ref_clk, rst_n, wr_en, rd_en, cpu_wake, ok;
  logic [15:0] addr;
  logic [7:0] wr_data, t1_hi, rv;
  logic [8:0] fr;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  wire rxd, txd, irq, stop_req, idle_req, power_down;
  wire [7:0] rd_data_q;
  wire [15:0] irq_vector_q;
  dual_uart_baud_select u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wr_data(wr_data), .rd_data_q(rd_data_q), .rxd(rxd), .txd(txd),
    .timer1_upper_byte(t1_hi), .cpu_wake(cpu_wake), .irq(irq), .irq_vector_q(irq_vector_q),
    .stop_req(stop_req), .idle_req(idle_req), .power_down(power_down));
  host_uart_model u_host (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    rv = rd_data_q;
    chk(n, {8'h00, rv}, {8'h00, e});
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // bounded wait for the interrupt, then let the vector register follow
  task automatic wirq(input logic [15:0] vec, input logic [7:0] clr);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (2) @(posedge ref_clk);
    chk("vector", irq_vector_q, vec);
    wr(`OFS_INT_STAT, clr);
    @(posedge ref_clk);
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_regs;
    rchk(`OFS_POWER_CTL, 8'h00, "power reset");
    rchk(`OFS_BAUD_SRC, 8'h00, "source reset");
    rchk(`OFS_PIN_ROUTE, 8'h00, "route reset");
    rchk(16'h0001, 8'h00, "unmapped");
    $display("done regs");
  endtask
  task automatic t_power;
    wr(`OFS_POWER_CTL, 8'h8F);
    @(posedge ref_clk);
    chk("stop", {15'h0000, stop_req}, 16'h0001);
    chk("idle", {15'h0000, idle_req}, 16'h0001);
    cpu_wake <= 1'b1;
    @(posedge ref_clk);
    cpu_wake <= 1'b0;
    @(posedge ref_clk);
    chk("woken", {14'h0000, stop_req, idle_req}, 16'h0000);
    rchk(`OFS_POWER_CTL, 8'h8C, "power kept");
    $display("done power");
  endtask
  // generator reload left at zero would be far too slow, so a good byte proves timer 1 drives
  task automatic t_timer1;
    wr(`OFS_CH0_CTL, 8'h40);
    wr(`OFS_INT_MASK, 8'h02);
    wr(`OFS_CH0_BUF, 8'h96);
    u_host.recv(CPB, 8, fr, ok);
    chk("timer byte", {7'h00, fr}, 16'h0096);
    chk("timer frame", {15'h0000, ok}, 16'h0001);
    wirq(`VEC_CH0, 8'h02);
    $display("done timer1");
  endtask
  task automatic t_tx0;
    wr(`OFS_BAUD_SRC, 8'h80);
    wr(`OFS_CH0_REL_LO, 8'hFF);
    wr(`OFS_CH0_REL_HI, 8'h03);
    wr(`OFS_CH0_BUF, 8'h4B);
    u_host.recv(CPB, 8, fr, ok);
    chk("tx0 byte", {7'h00, fr}, 16'h004B);
    chk("tx0 frame", {15'h0000, ok}, 16'h0001);
    wirq(`VEC_CH0, 8'h02);
    $display("done tx0");
  endtask
  task automatic t_rx0;
    wr(`OFS_CH0_CTL, 8'h50);
    wr(`OFS_INT_MASK, 8'h01);
    u_host.send(8'hBC, CPB);
    wirq(`VEC_CH0, 8'h01);
    rchk(`OFS_CH0_BUF, 8'hBC, "rx0 byte");
    $display("done rx0");
  endtask
  // mode 2 with doubling: 32 clocks a bit, tb8 sent as the ninth bit
  task automatic t_mode2;
    wr(`OFS_CH0_CTL, 8'h88);
    wr(`OFS_CH0_BUF, 8'hA5);
    u_host.recv(32, 9, fr, ok);
    chk("mode2 frame", {7'h00, fr}, 16'h01A5);
    chk("mode2 stop", {15'h0000, ok}, 16'h0001);
    $display("done mode2");
  endtask
  // odd parity over 0x4B (four ones) puts a one in the ninth bit
  task automatic t_ch1;
    wr(`OFS_PIN_ROUTE, 8'h01);
    wr(`OFS_CH1_REL_LO, 8'hFF);
    wr(`OFS_CH1_REL_HI, 8'h03);
    wr(`OFS_FRAME_CFG, 8'h10);
    wr(`OFS_CH1_CTL, 8'h20);
    wr(`OFS_INT_MASK, 8'h08);
    wr(`OFS_CH1_BUF, 8'h4B);
    u_host.recv(CPB, 9, fr, ok);
    chk("ch1 frame", {7'h00, fr}, 16'h014B);
    chk("ch1 stop", {15'h0000, ok}, 16'h0001);
    wirq(`VEC_CH1, 8'h08);
    wr(`OFS_PIN_ROUTE, 8'h00);
    $display("done ch1");
  endtask
  // loopback: channel 0 in mode 3 feeds channel 1, software ninth bit via tb8; power down bit rides along
  task automatic t_loop;
    wr(`OFS_PIN_ROUTE, 8'h82);
    wr(`OFS_CH1_CTL, 8'h10);
    wr(`OFS_INT_MASK, 8'h04);
    chk("power down", {15'h0000, power_down}, 16'h0001);
    wr(`OFS_CH0_CTL, 8'hC8);
    wr(`OFS_CH0_BUF, 8'h5A);
    wirq(`VEC_CH1, 8'h04);
    rchk(`OFS_CH1_BUF, 8'h5A, "loop byte");
    rchk(`OFS_CH1_CTL, 8'h14, "loop ninth");
    wr(`OFS_INT_MASK, 8'h00);
    wr(`OFS_PIN_ROUTE, 8'h00);
    $display("done loop");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // main sequence; timer 1 upper byte held at 0xFF gives the same rate as the generator
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    cpu_wake = 1'b0;
    addr = 16'h0000;
    wr_data = 8'h00;
    t1_hi = 8'hFF;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_power;
    t_timer1;
    t_tx0;
    t_rx0;
    t_mode2;
    t_ch1;
    t_loop;
    final_report;
  end
  // a hung wait ends the run as a mismatch
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      final_report;
    end
  end
endmodule // tb_top
bind dual_uart_baud_select dual_uart_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .wr_data(wr_data), .rd_data_q(rd_data_q), .txd(txd), .cpu_wake(cpu_wake), .irq(irq),
  .irq_vector_q(irq_vector_q), .stop_req(stop_req), .idle_req(idle_req), .power_down(power_down));
`default_nettype wire
